// file: include/btb_regs.vh
`ifndef BTB_REGS_VH
`define BTB_REGS_VH

// Register indexes; byte address is four times the index
`define BTB_IDX_ISL 16'hfe5f
`define BTB_IDX_CTRL 16'hfe7f
`define BTB_IDX_COUNT 16'hfe7c

// Reset values
`define BTB_ISL_RESET 8'h00
`define BTB_CTRL_RESET 8'h00

// Control register fields
`define BTB_CTRL_FAST 7
`define BTB_CTRL_RUN 6
`define BTB_CTRL_PER_HI 5
`define BTB_CTRL_PER_LO 4
`define BTB_CTRL_IF1 3
`define BTB_CTRL_IE1 2
`define BTB_CTRL_IF0 1
`define BTB_CTRL_IE0 0

// Input select register fields
`define BTB_ISL_CLK_HI 5
`define BTB_ISL_CLK_LO 4
`define BTB_ISL_BUZ 3

// Count clock select codes
`define BTB_CLK_CYCLE 2'h1
`define BTB_CLK_T0PRE 2'h3

// Counter register write field
`define BTB_COUNT_CLEAR 0

// Interrupt 1 period masks in count clocks minus one
`define BTB_P32_MASK 14'h001f
`define BTB_P128_MASK 14'h007f
`define BTB_P512_MASK 14'h01ff
`define BTB_P2048_MASK 14'h07ff
`define BTB_P2_MASK 14'h0001
`define BTB_P8_MASK 14'h0007

// AXI responses
`define BTB_RESP_OKAY 2'h0
`define BTB_RESP_SLVERR 2'h2

`endif

// file: src/btb_counter.v
`timescale 1ns/1ps
`include "btb_regs.vh"

module btb_counter #(
	parameter LO_W = 8,
	parameter HI_W = 6
) (
	input wire sys_clk,
	input wire resetn,
	input wire tick,
	input wire clear,
	input wire fast,
	input wire runCtl,
	input wire [1:0] periodSel,
	output wire [LO_W+HI_W-1:0] count,
	output wire int0Set,
	output wire int1Set,
	output wire buzzer
);

	localparam W = LO_W + HI_W;

	reg [LO_W-1:0] lo_q;
	reg [HI_W-1:0] hi_q;
	wire loFull;
	wire hiFull;
	wire active;
	wire step;
	wire hiStep;
	wire [W-1:0] mask;

	function [13:0] int1Mask;
		input f;
		input [1:0] s;
		begin
			case (s)
				2'h0: int1Mask = `BTB_P32_MASK;
				2'h1: int1Mask = `BTB_P128_MASK;
				2'h2: int1Mask = f ? `BTB_P2_MASK : `BTB_P512_MASK;
				default: int1Mask = f ? `BTB_P8_MASK : `BTB_P2048_MASK;
			endcase
		end
	endfunction

	assign count = {hi_q, lo_q};
	assign loFull = &lo_q;
	assign hiFull = &hi_q;
	// Stopped only once the count has come back to zero
	assign active = runCtl | (|count); // [R7]
	assign step = tick & active;
	// Fast mode feeds the upper stage straight from the count clock
	assign hiStep = fast ? step : (step & loFull); // [R4] [R1]
	assign mask = int1Mask(fast, periodSel);

	always @(posedge sys_clk) begin
		if (!resetn) begin
			lo_q <= {LO_W{1'b0}};
			hi_q <= {HI_W{1'b0}};
		end else if (clear) begin // [R2]
			lo_q <= {LO_W{1'b0}};
			hi_q <= {HI_W{1'b0}};
		end else begin
			if (step) begin
				lo_q <= lo_q + 1'b1; // [R1]
			end
			if (hiStep) begin
				hi_q <= hi_q + 1'b1;
			end
		end
	end

	assign int0Set = fast ? (step & hiFull) : (step & loFull & hiFull); // [R5]
	// Period masks below 256 come from the lower stage alone
	assign int1Set = step & ((count & mask) == mask); // [R8] [R16] [R13]
	assign buzzer = lo_q[3]; // [R16]

endmodule // btb_counter

// file: src/btb_pinmux.v
`timescale 1ns/1ps
`include "btb_regs.vh"

module btb_pinmux (
	input wire sys_clk,
	input wire resetn,
	input wire buzzerSelect,
	input wire pinFunction,
	input wire buzzerSrc,
	input wire timer1HighPwm,
	input wire portLatch,
	output reg pinOut_q,
	output reg pwmhOut_q,
	output reg buzzerOut_q
);

	wire buzD;
	wire pwmD;

	assign buzD = buzzerSelect ? buzzerSrc : 1'b1; // [R14] [R15]
	assign pwmD = buzzerSelect ? 1'b1 : timer1HighPwm; // [R14] [R15]

	always @(posedge sys_clk) begin
		if (!resetn) begin
			pinOut_q <= 1'b0;
			pwmhOut_q <= 1'b1;
			buzzerOut_q <= 1'b1;
		end else begin
			buzzerOut_q <= buzD;
			pwmhOut_q <= pwmD;
			// Buzzer and PWM both high when unselected, so AND picks one
			pinOut_q <= pinFunction ? (buzD & pwmD) : portLatch; // [R14]
		end
	end

endmodule // btb_pinmux

// file: src/btb_top.v
// Behaviour
// [R1] Fourteen bits from cascaded eight and six
// [R2] Software can clear the counters
// [R3] Select field picks sub, cycle, prescaler clock
// [R4] Upper stage fed directly or by overflow
// [R5] Interrupt 0 every 64 or 16384 clocks
// [R6] Software sets fast bit for fast mode
// [R7] Run bit low stops at zero count
// [R8] Interrupt 1 period from fast and period
// [R9] Interrupt 1 flag set per period, write clears
// [R10] Interrupt 0 flag set per period, write clears
// [R11] Enabled interrupt 1 raises release and request
// [R12] Enabled interrupt 0 raises release and request
// [R13] Period rewrite may set interrupt 1 flag
// [R14] Buzzer selected: pin gets clock over 16
// [R15] Buzzer deselected: pin gets PWM output
// [R16] Lower stage makes buzzer and interrupt 1; the 512 and 2048 periods also use the upper stage
// [R17] Keeps counting in hold if enabled
// [R18] Software keeps cycle clock below half period
// [R19] Software stops timer before hold on subclock
// [R20] Software stops timer before changing source
// [R21] One level request while any enabled flag
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "btb_regs.vh"

module btb_top #(
	parameter ADDR_W = 18,
	parameter LO_W = 8,
	parameter HI_W = 6
) (
	input wire sys_clk,
	input wire resetn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire subClock,
	input wire cycleClock,
	input wire t0Prescaler,
	input wire holdMode,
	input wire holdRunEnable,
	input wire pinFunction,
	input wire timer1HighPwm,
	input wire portLatch,
	output reg baseTimerIrq,
	output reg xtalHoldRelease,
	output wire pinOut,
	output wire pwmhOut,
	output wire buzzerOut
);

	localparam W = LO_W + HI_W;

	// Register file
	reg [7:0] isl_q;
	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	reg clear_q;
	reg clear_d;

	// Write channel state
	reg [ADDR_W-1:0] awAddr_q;
	reg awHeld_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg wHeld_q;

	// Count clock edge detection
	reg srcPrev_q;
	reg srcSel;
	wire srcRise;
	wire tick;

	wire [W-1:0] count;
	wire int0Set;
	wire int1Set;
	wire buzzerSrc;
	wire doWrite;
	wire arTake;
	wire [15:0] wrIdx;
	wire [15:0] rdIdx;

	function mapped;
		input [15:0] idx;
		begin
			mapped = (idx == `BTB_IDX_ISL) || (idx == `BTB_IDX_CTRL) ||
				(idx == `BTB_IDX_COUNT);
		end
	endfunction

	assign wrIdx = awAddr_q[17:2];
	assign rdIdx = s_axi_araddr[17:2];

	// Source select, codes 00 and 10 both take the subclock
	always @* begin
		case (isl_q[`BTB_ISL_CLK_HI:`BTB_ISL_CLK_LO])
			`BTB_CLK_CYCLE: srcSel = cycleClock; // [R3]
			`BTB_CLK_T0PRE: srcSel = t0Prescaler; // [R3]
			default: srcSel = subClock; // [R3]
		endcase
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			srcPrev_q <= 1'b0;
		end else begin
			srcPrev_q <= srcSel;
		end
	end

	assign srcRise = srcSel & ~srcPrev_q;
	// In hold the count clock is gated unless hold running is enabled
	assign tick = srcRise & (~holdMode | holdRunEnable); // [R17]

	btb_counter #(
		.LO_W(LO_W),
		.HI_W(HI_W)
	) u_counter (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.tick(tick),
		.clear(clear_q),
		.fast(ctrl_q[`BTB_CTRL_FAST]),
		.runCtl(ctrl_q[`BTB_CTRL_RUN]),
		.periodSel(ctrl_q[`BTB_CTRL_PER_HI:`BTB_CTRL_PER_LO]),
		.count(count),
		.int0Set(int0Set),
		.int1Set(int1Set),
		.buzzer(buzzerSrc)
	);

	btb_pinmux u_pinmux (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.buzzerSelect(isl_q[`BTB_ISL_BUZ]),
		.pinFunction(pinFunction),
		.buzzerSrc(buzzerSrc),
		.timer1HighPwm(timer1HighPwm),
		.portLatch(portLatch),
		.pinOut_q(pinOut),
		.pwmhOut_q(pwmhOut),
		.buzzerOut_q(buzzerOut)
	);

	// Write performed once both address and data are held
	assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
	assign arTake = s_axi_arvalid & s_axi_arready;

	// Control register next value; hardware flag sets win over writes
	always @* begin
		ctrl_d = ctrl_q;
		clear_d = 1'b0;
		if (doWrite && wStrb_q[0]) begin
			if (wrIdx == `BTB_IDX_CTRL) begin
				ctrl_d = wData_q[7:0]; // [R6] [R20]
			end
			if (wrIdx == `BTB_IDX_COUNT) begin
				clear_d = wData_q[`BTB_COUNT_CLEAR]; // [R2]
			end
		end
		if (int1Set) begin
			ctrl_d[`BTB_CTRL_IF1] = 1'b1; // [R9]
		end
		if (int0Set) begin
			ctrl_d[`BTB_CTRL_IF0] = 1'b1; // [R10]
		end
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl_q <= `BTB_CTRL_RESET;
			isl_q <= `BTB_ISL_RESET;
			clear_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			clear_q <= clear_d;
			if (doWrite && wStrb_q[0] && wrIdx == `BTB_IDX_ISL) begin
				isl_q <= wData_q[7:0]; // [R3]
			end
		end
	end

	// Interrupt request and hold release, one cycle after the flag
	always @(posedge sys_clk) begin
		if (!resetn) begin
			baseTimerIrq <= 1'b0;
			xtalHoldRelease <= 1'b0;
		end else begin
			baseTimerIrq <= (ctrl_q[`BTB_CTRL_IF1] & ctrl_q[`BTB_CTRL_IE1]) |
				(ctrl_q[`BTB_CTRL_IF0] & ctrl_q[`BTB_CTRL_IE0]); // [R11] [R12] [R21]
			xtalHoldRelease <= (ctrl_q[`BTB_CTRL_IF1] &
				ctrl_q[`BTB_CTRL_IE1]) |
				(ctrl_q[`BTB_CTRL_IF0] & ctrl_q[`BTB_CTRL_IE0]); // [R11] [R12] [R17]
		end
	end

	// Write address and data channels, taken in either order
	always @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= {ADDR_W{1'b0}};
			wData_q <= 32'h0;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BTB_RESP_OKAY;
		end else begin
			if (!awHeld_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (!wHeld_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHeld_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wrIdx) ? `BTB_RESP_OKAY :
					`BTB_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel, answer one cycle after the address is taken
	always @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `BTB_RESP_OKAY;
		end else begin
			if (!s_axi_rvalid && !arTake) begin
				s_axi_arready <= 1'b1;
			end
			if (arTake) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(rdIdx) ? `BTB_RESP_OKAY :
					`BTB_RESP_SLVERR;
				case (rdIdx)
					`BTB_IDX_ISL: s_axi_rdata <= {24'h0, isl_q};
					`BTB_IDX_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
					`BTB_IDX_COUNT: s_axi_rdata <= {{(32-W){1'b0}}, count};
					default: s_axi_rdata <= 32'h0;
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // btb_top

// file: verification/btb_top_properties.sv
`timescale 1ns/1ps
module btb_top_properties (
	input wire sys_clk,
	input wire resetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire pinFunction,
	input wire timer1HighPwm,
	input wire portLatch,
	input wire baseTimerIrq,
	input wire xtalHoldRelease,
	input wire pinOut,
	input wire pwmhOut,
	input wire buzzerOut
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	chk_irq_wake: assert property (
		baseTimerIrq == xtalHoldRelease) else $error("wake differs");
	chk_buz_pwm: assert property (
		!buzzerOut |-> pwmhOut) else $error("pwm not held high");
	chk_pwm_pass: assert property (
		!pwmhOut |-> !$past(timer1HighPwm)) else $error("pwm not passed");
	chk_pin_mux: assert property (
		$past(resetn, 2) && $past(pinFunction)
		|-> pinOut == (buzzerOut && pwmhOut)) else $error("pin mux");
	chk_pin_latch: assert property (
		$past(resetn, 2) && !$past(pinFunction)
		|-> pinOut == $past(portLatch)) else $error("pin latch");
	chk_irq_fall: assert property (
		$fell(baseTimerIrq) |-> $past(s_axi_bvalid)
		|| $past(s_axi_bvalid, 2)) else $error("irq fell alone");
	chk_rd_lat: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read late");
	chk_wr_lat: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write late");
	cover property ($rose(baseTimerIrq));
	cover property (!buzzerOut);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // btb_top_properties

bind btb_top btb_top_properties i_chk (.*);

// file: verification/test_base_timer_buzzer.sv
`timescale 1ns/1ps
`include "btb_regs.vh"
module test_base_timer_buzzer;
	logic sys_clk = 0, resetn = 0;
	logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic subClock = 0, cycleClock = 0, t0Prescaler = 0;
	logic holdMode = 0, holdRunEnable = 0, pinFunction = 0;
	logic timer1HighPwm = 0, portLatch = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire baseTimerIrq, xtalHoldRelease, pinOut, pwmhOut, buzzerOut;
	logic [33:0] eR[$];
	logic [1:0] eB[$];
	int error_cnt = 0, compares = 0, cyc = 0;
	int pt[8] = '{32, 128, 512, 2048, 32, 128, 2, 8};
	logic [7:0] c;
	logic f0;

	btb_top i_btb_top (.*);

	always #25 sys_clk = ~sys_clk;

	task finish_test;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input [33:0] e, g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task cmpR(input [33:0] e, g);
		chk(e, g);
	endtask
	task cmpB(input [1:0] e, g);
		chk(34'(e), 34'(g));
	endtask
	// Pin expectation from inputs sampled at the launching edge
	task cmpP(input [1:0] e, input s);
		logic x;
		x = pinFunction ? &e : portLatch;
		@(negedge sys_clk);
		if (s)
			chk(34'({x, e}), 34'({pinOut, buzzerOut, pwmhOut}));
		else
			chk(34'(e), 34'({baseTimerIrq, xtalHoldRelease}));
		@(posedge sys_clk);
	endtask

	task wr(input [15:0] i, input [7:0] d, input [1:0] e = 2'h0);
		eB.push_back(e);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge sys_clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge sys_clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task rd(input [15:0] i, input [31:0] d, input [1:0] e = 2'h0);
		eR.push_back({e, d});
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Rising edges on the chosen count clock inputs
	task tk(input int n, input [2:0] m);
		repeat (n) begin
			{t0Prescaler, cycleClock, subClock} <= m;
			@(posedge sys_clk);
			{t0Prescaler, cycleClock, subClock} <= 3'h0;
			@(posedge sys_clk);
		end
	endtask

	always @(posedge sys_clk) begin
		if (s_axi_rvalid && s_axi_rready)
			cmpR(eR.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			cmpB(eB.pop_front(), s_axi_bresp);
		{pinFunction, timer1HighPwm, portLatch} <= 3'($urandom);
		if (++cyc == 80000) begin
			error_cnt++;
			finish_test;
		end
	end

	initial begin
		void'($urandom(32'h12ee));
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rd(`BTB_IDX_CTRL, 32'h0);
		rd(`BTB_IDX_ISL, 32'h0);
		rd(16'h0000, 32'h0, `BTB_RESP_SLVERR);
		wr(16'h0001, 8'hff, `BTB_RESP_SLVERR);
		// Byte lane 0 off: write ignored, still OKAY
		s_axi_wstrb <= 4'he;
		wr(`BTB_IDX_CTRL, 8'hff);
		s_axi_wstrb <= 4'hf;
		rd(`BTB_IDX_CTRL, 32'h0);
		tk(5, 3'h7);
		rd(`BTB_IDX_COUNT, 32'h0);
		for (int s = 0; s < 4; s++) begin
			wr(`BTB_IDX_ISL, 8'(s << 4));
			wr(`BTB_IDX_CTRL, 8'h40);
			wr(`BTB_IDX_COUNT, 8'h01);
			tk(3, 3'h1);
			tk(5, 3'h2);
			tk(9, 3'h4);
			rd(`BTB_IDX_COUNT, s[0] ? (s[1] ? 32'h9 : 32'h5) : 32'h3);
		end
		wr(`BTB_IDX_COUNT, 8'h01);
		holdMode <= 1'b1;
		tk(4, 3'h4);
		holdRunEnable <= 1'b1;
		tk(300, 3'h4);
		holdMode <= 1'b0;
		rd(`BTB_IDX_COUNT, 32'h12c);
		for (int j = 0; j < 8; j++) begin
			c = {j[2], 1'b1, j[1:0], 4'h0};
			f0 = j > 3 && pt[j] > 64;
			wr(`BTB_IDX_CTRL, c);
			wr(`BTB_IDX_COUNT, 8'h01);
			tk(pt[j] - 1, 3'h4);
			rd(`BTB_IDX_CTRL, {24'h0, c[7:4], 2'h0, f0, 1'b0});
			tk(1, 3'h4);
			rd(`BTB_IDX_CTRL, {24'h0, c[7:4], 2'h2, f0, 1'b0});
		end
		wr(`BTB_IDX_CTRL, 8'h40);
		wr(`BTB_IDX_COUNT, 8'h01);
		tk(16383, 3'h4);
		rd(`BTB_IDX_CTRL, 32'h48);
		wr(`BTB_IDX_CTRL, 8'h00);
		tk(4, 3'h4);
		rd(`BTB_IDX_CTRL, 32'h0a);
		rd(`BTB_IDX_COUNT, 32'h0);
		wr(`BTB_IDX_CTRL, 8'h4c);
		cmpP(2'h3, 1'b0);
		wr(`BTB_IDX_CTRL, 8'h44);
		cmpP(2'h0, 1'b0);
		wr(`BTB_IDX_CTRL, 8'hc1);
		tk(64, 3'h4);
		cmpP(2'h3, 1'b0);
		wr(`BTB_IDX_ISL, 8'h38);
		wr(`BTB_IDX_CTRL, 8'h40);
		wr(`BTB_IDX_COUNT, 8'h01);
		cmpP(2'h1, 1'b1);
		tk(8, 3'h4);
		cmpP(2'h3, 1'b1);
		wr(`BTB_IDX_ISL, 8'h30);
		cmpP({1'b1, timer1HighPwm}, 1'b1);
		finish_test;
	end
endmodule // test_base_timer_buzzer
